// file: branch_seq_defs.vh
// constants shared by the branch and event sequencer and its condition evaluator
// assumes inclusion by bare name from files in the same folder
`ifndef BRANCH_SEQ_DEFS_VH
`define BRANCH_SEQ_DEFS_VH

// ----------------------------------------------------------------
// branch kinds presented by decode
// ----------------------------------------------------------------
`define KIND_REL        3'h0
`define KIND_JUMP_IND   3'h1
`define KIND_CALL_REL   3'h2
`define KIND_CALL_IND   3'h3
`define KIND_RETURN     3'h4

// ----------------------------------------------------------------
// condition codes of relative branches
// ----------------------------------------------------------------
`define COND_ALWAYS     4'h0
`define COND_NEVER      4'h1
`define COND_EQ         4'h2
`define COND_NE         4'h3
`define COND_CS         4'h4
`define COND_CC         4'h5
`define COND_MI         4'h6
`define COND_PL         4'h7
`define COND_VS         4'h8
`define COND_VC         4'h9
`define COND_LT         4'hA
`define COND_GE         4'hB
`define COND_LE         4'hC
`define COND_GT         4'hD
`define COND_LS         4'hE
`define COND_HI         4'hF

// ----------------------------------------------------------------
// flag positions in the nzvc vector
// ----------------------------------------------------------------
`define FLAG_N          3
`define FLAG_Z          2
`define FLAG_V          1
`define FLAG_C          0

// ----------------------------------------------------------------
// program status fields
// ----------------------------------------------------------------
`define PS_IFLAG_BIT    4
`define PS_ILM_HI       20
`define PS_ILM_LO       16

// ----------------------------------------------------------------
// event vectors and levels
// ----------------------------------------------------------------
`define VEC_EMULATOR    8'h09
`define VEC_STEP_TRACE  8'h0C
`define VEC_UNDEFINED   8'h0E
`define VEC_NMI         8'h0F
`define LEVEL_NMI       5'h0F

// ----------------------------------------------------------------
// stack frame and reset values
// ----------------------------------------------------------------
`define FRAME_BYTES     32'h0000_0008
`define SSP_RESET       32'h0000_0000

`endif

// file: branch_condition_eval.v
// condition evaluator for relative branches
// assumes flags come from the state before the branch retires
`timescale 1ns/100ps

module branch_condition_eval (
	input  wire [3:0] cond,
	input  wire [3:0] flags_nzvc,
	output reg        cond_true
);

`include "branch_seq_defs.vh"

	wire n;
	wire z;
	wire v;
	wire c;

	// ----------------------------------------------------------------
	// flag decode
	// ----------------------------------------------------------------
	assign n = flags_nzvc[`FLAG_N];
	assign z = flags_nzvc[`FLAG_Z];
	assign v = flags_nzvc[`FLAG_V];
	assign c = flags_nzvc[`FLAG_C];

	// one decision per code; odd codes invert their even partner
	always @* begin
		case (cond)
			`COND_ALWAYS: cond_true = 1'b1;
			`COND_NEVER:  cond_true = 1'b0;
			`COND_EQ:     cond_true = z;
			`COND_NE:     cond_true = ~z;
			`COND_CS:     cond_true = c;
			`COND_CC:     cond_true = ~c;
			`COND_MI:     cond_true = n;
			`COND_PL:     cond_true = ~n;
			`COND_VS:     cond_true = v;
			`COND_VC:     cond_true = ~v;
			`COND_LT:     cond_true = n ^ v;
			`COND_GE:     cond_true = ~(n ^ v);
			`COND_LE:     cond_true = (n ^ v) | z;
			`COND_GT:     cond_true = ~((n ^ v) | z);
			`COND_LS:     cond_true = c | z;
			`COND_HI:     cond_true = ~(c | z);
			default:      cond_true = 1'b0;
		endcase
	end

endmodule

// file: branch_sequencer.v
// branch and event sequencer at the execute stage of a single-issue core
// assumes decode, register file and interrupt controller run on clk_sys;
// all inputs are same-domain and need no synchronisers
//
// What this block does
// - delayed branch runs next instruction first
// - delayed jump, call, return, all branches
// - conditional delayed slot always executes
// - only pc update moves; registers stay ordered
// - indirect target sampled before slot writes
// - delayed return uses pre-slot return pointer
// - delayed condition uses pre-slot flags
// - slot reading return pointer sees call
// - no step trace inside delayed pair
// - no interrupt or nmi inside pair
// - undefined opcode in slot acts as nop
// - taken delayed branch costs one cycle
// - non-delayed branch skips sequential instruction
// - non-delayed taken two cycles, untaken one
// - exception resumes at faulting instruction
// - trap resumes at following instruction
// - recognise all listed event causes
// - return from event restores pc and status
// - fifteen usable user priority levels
// - accept only level below current mask
// - stack pointer minus eight on entry, plus on return
`timescale 1ns/100ps

module branch_sequencer #(
	parameter [7:0] COP_ABSENT_VEC  = 8'h0B,
	parameter [7:0] COP_ERROR_VEC   = 8'h0A,
	parameter [7:0] DELAYED_IRQ_VEC = 8'h3F
) (
	input  wire        clk_sys,
	input  wire        reset_n,
	input  wire        ex_valid,
	input  wire [31:0] ex_pc,
	input  wire [31:0] ex_next_pc,
	input  wire [31:0] ex_link_addr,
	input  wire        ex_is_branch,
	input  wire        ex_delayed,
	input  wire [2:0]  ex_kind,
	input  wire [3:0]  ex_cond,
	input  wire [31:0] ex_rel_target,
	input  wire        ex_undefined,
	input  wire        ex_soft_trap,
	input  wire [7:0]  ex_soft_trap_vec,
	input  wire        ex_emulator_trap,
	input  wire        ex_cop_absent,
	input  wire        ex_cop_error,
	input  wire        ex_return_from_event,
	input  wire [31:0] general_register_operand,
	input  wire [31:0] return_pointer,
	input  wire [3:0]  flags_nzvc,
	input  wire [31:0] program_status,
	input  wire [31:0] restored_pc,
	input  wire [31:0] restored_ps,
	input  wire        step_trace_en,
	input  wire        nmi_req,
	input  wire        irq_req,
	input  wire [4:0]  irq_level,
	input  wire [7:0]  irq_vector,
	input  wire        delayed_irq_req,
	input  wire [4:0]  delayed_irq_level,
	output reg         redirect_valid_ff,
	output reg  [31:0] redirect_pc_ff,
	output reg         flush_ff,
	output reg         slot_active_ff,
	output reg         slot_nop_ff,
	output reg  [31:0] slot_rp_ff,
	output reg         rp_wr_en_ff,
	output reg  [31:0] rp_wr_data_ff,
	output reg         evt_enter_ff,
	output reg  [7:0]  evt_vector_ff,
	output reg  [31:0] evt_push_pc_ff,
	output reg  [31:0] evt_push_ps_ff,
	output reg  [31:0] evt_push_addr_ff,
	output reg         ps_restore_valid_ff,
	output reg  [31:0] ps_restore_ff,
	output reg  [31:0] system_stack_pointer_ff
);

`include "branch_seq_defs.vh"

	// ----------------------------------------------------------------
	// states, one-hot
	// ----------------------------------------------------------------
	localparam [2:0] ST_RUN  = 3'h1;
	localparam [2:0] ST_SLOT = 3'h2;
	localparam [2:0] ST_DROP = 3'h4;

	reg  [2:0]  state_ff;
	reg  [2:0]  nxt_state;
	reg         slot_taken_ff;
	reg  [31:0] slot_target_ff;

	wire        cond_true;
	wire        in_slot;
	wire        retire;
	wire        is_br;
	wire        is_call;
	wire        cond_ok;
	wire        br_taken;
	wire        nd_taken;
	wire        d_br;
	wire        return_from_event;
	wire        async_ok;
	wire        iflag;
	wire [4:0]  interrupt_level_mask;
	reg  [31:0] br_target;
	reg  [31:0] successor;
	reg         evt_take;
	reg  [7:0]  evt_vec;
	reg  [31:0] evt_save_pc;
	reg  [31:0] ssp_after_return_from_event;

	// level test shared by every maskable source
	function level_passes;
		input [4:0] level;
		input [4:0] mask;
		begin
			level_passes = (level < mask);
		end
	endfunction

	// ----------------------------------------------------------------
	// condition evaluation
	// ----------------------------------------------------------------
	// flags sampled at branch
	branch_condition_eval u_cond (
		.cond       (ex_cond),
		.flags_nzvc (flags_nzvc),
		.cond_true  (cond_true)
	);

	// ----------------------------------------------------------------
	// retirement decode
	// ----------------------------------------------------------------
	// the cycle after a discard is dead: the wrong-path word there is killed
	assign in_slot  = state_ff[1];
	assign retire   = ex_valid & ~state_ff[2];
	// a branch in the slot is the stream's fault; it is not honoured
	assign is_br    = retire & ex_is_branch & ~in_slot;
	assign is_call  = (ex_kind == `KIND_CALL_REL) | (ex_kind == `KIND_CALL_IND);
	assign cond_ok  = (ex_kind == `KIND_REL) ? cond_true : 1'b1;
	assign br_taken = is_br & cond_ok;
	assign nd_taken = br_taken & ~ex_delayed;
	// every kind has a delayed form
	assign d_br     = is_br & ex_delayed;
	assign return_from_event     = retire & ex_return_from_event;
	// nothing asynchronous at the branch half
	assign async_ok = retire & ~d_br;
	assign iflag    = program_status[`PS_IFLAG_BIT];
	assign interrupt_level_mask      = program_status[`PS_ILM_HI:`PS_ILM_LO];

	// ----------------------------------------------------------------
	// branch target select
	// ----------------------------------------------------------------
	// register value before slot
	always @* begin
		case (ex_kind)
			`KIND_REL:      br_target = ex_rel_target;
			`KIND_CALL_REL: br_target = ex_rel_target;
			`KIND_JUMP_IND: br_target = general_register_operand;
			`KIND_CALL_IND: br_target = general_register_operand;
			`KIND_RETURN:   br_target = return_pointer;
			default:        br_target = ex_next_pc;
		endcase
	end

	// address that follows the retiring instruction in program order
	// trap resumes after instruction
	always @* begin
		if (return_from_event) begin
			successor = restored_pc;
		end else if (nd_taken) begin
			successor = br_target;
		end else if (in_slot & slot_taken_ff) begin
			successor = slot_target_ff;
		end else begin
			successor = ex_next_pc;
		end
	end

	// ----------------------------------------------------------------
	// event selection, fixed priority
	// ----------------------------------------------------------------
	// all causes recognised here
	always @* begin
		evt_take    = 1'b0;
		evt_vec     = `VEC_UNDEFINED;
		evt_save_pc = successor;
		if (retire & ex_undefined & ~in_slot) begin
			evt_take    = 1'b1;
			evt_vec     = `VEC_UNDEFINED;
			evt_save_pc = ex_pc;
		end else if (retire & ex_cop_absent) begin
			evt_take = 1'b1;
			evt_vec  = COP_ABSENT_VEC;
		end else if (retire & ex_cop_error) begin
			evt_take = 1'b1;
			evt_vec  = COP_ERROR_VEC;
		end else if (retire & ex_soft_trap) begin
			evt_take = 1'b1;
			evt_vec  = ex_soft_trap_vec;
		end else if (retire & ex_emulator_trap) begin
			evt_take = 1'b1;
			evt_vec  = `VEC_EMULATOR;
		end else if (async_ok & nmi_req & level_passes(`LEVEL_NMI, interrupt_level_mask)) begin
			evt_take = 1'b1;
			evt_vec  = `VEC_NMI;
		end else if (async_ok & iflag & delayed_irq_req &
				level_passes(delayed_irq_level, interrupt_level_mask)) begin
			evt_take = 1'b1;
			evt_vec  = DELAYED_IRQ_VEC;
		end else if (async_ok & iflag & irq_req & level_passes(irq_level, interrupt_level_mask)) begin
			evt_take = 1'b1;
			evt_vec  = irq_vector;
		end else if (async_ok & step_trace_en) begin
			evt_take = 1'b1;
			evt_vec  = `VEC_STEP_TRACE;
		end
	end

	// return frame popped before new push
	always @* begin
		if (return_from_event) begin
			ssp_after_return_from_event = system_stack_pointer_ff + `FRAME_BYTES;
		end else begin
			ssp_after_return_from_event = system_stack_pointer_ff;
		end
	end

	// ----------------------------------------------------------------
	// sequencing state
	// ----------------------------------------------------------------
	always @* begin
		case (state_ff)
			ST_RUN: begin
				if (evt_take | nd_taken | return_from_event) begin
					nxt_state = ST_DROP;
				end else if (d_br) begin
					nxt_state = ST_SLOT;
				end else begin
					nxt_state = ST_RUN;
				end
			end
			ST_SLOT: begin
				if (retire & (evt_take | return_from_event)) begin
					nxt_state = ST_DROP;
				end else if (retire) begin
					nxt_state = ST_RUN;
				end else begin
					nxt_state = ST_SLOT;
				end
			end
			ST_DROP: nxt_state = ST_RUN;
			default: nxt_state = ST_RUN;
		endcase
	end

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			state_ff <= ST_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ----------------------------------------------------------------
	// pc redirection and discard
	// ----------------------------------------------------------------
	// delayed taken redirects at once: the slot is already fetched,
	// so the target follows it with no bubble
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			redirect_valid_ff <= 1'b0;
			redirect_pc_ff    <= 32'h0000_0000;
			flush_ff          <= 1'b0;
			slot_taken_ff     <= 1'b0;
			slot_target_ff    <= 32'h0000_0000;
		end else begin
			redirect_valid_ff <= (br_taken | return_from_event) & ~evt_take;
			redirect_pc_ff    <= return_from_event ? restored_pc : br_target;
			flush_ff          <= nd_taken | return_from_event | evt_take;
			if (d_br) begin
				slot_taken_ff  <= cond_ok;
				slot_target_ff <= br_target;
			end
		end
	end

	// ----------------------------------------------------------------
	// slot side information and return pointer
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			slot_active_ff <= 1'b0;
			slot_nop_ff    <= 1'b0;
			slot_rp_ff     <= 32'h0000_0000;
			rp_wr_en_ff    <= 1'b0;
			rp_wr_data_ff  <= 32'h0000_0000;
		end else begin
			slot_active_ff <= (nxt_state == ST_SLOT);
			slot_nop_ff    <= retire & in_slot & ex_undefined;
			slot_rp_ff     <= (d_br & is_call) ? ex_link_addr : return_pointer;
			// link written at call, before slot
			rp_wr_en_ff    <= is_br & is_call & ~evt_take;
			rp_wr_data_ff  <= ex_link_addr;
		end
	end

	// ----------------------------------------------------------------
	// event entry, return and stack pointer
	// ----------------------------------------------------------------
	// return_from_event and a new entry in one cycle net to no stack change
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			evt_enter_ff            <= 1'b0;
			evt_vector_ff           <= 8'h00;
			evt_push_pc_ff          <= 32'h0000_0000;
			evt_push_ps_ff          <= 32'h0000_0000;
			evt_push_addr_ff        <= `SSP_RESET;
			ps_restore_valid_ff     <= 1'b0;
			ps_restore_ff           <= 32'h0000_0000;
			system_stack_pointer_ff <= `SSP_RESET;
		end else begin
			evt_enter_ff        <= evt_take;
			evt_vector_ff       <= evt_vec;
			evt_push_pc_ff      <= evt_save_pc;
			evt_push_ps_ff      <= return_from_event ? restored_ps : program_status;
			evt_push_addr_ff    <= ssp_after_return_from_event - `FRAME_BYTES;
			ps_restore_valid_ff <= return_from_event;
			ps_restore_ff       <= restored_ps;
			if (evt_take) begin
				system_stack_pointer_ff <= ssp_after_return_from_event - `FRAME_BYTES;
			end else begin
				system_stack_pointer_ff <= ssp_after_return_from_event;
			end
		end
	end

endmodule

// file: seq_checker.sv
// port checker for the branch and event sequencer
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/100ps
`include "branch_seq_defs.vh"
module seq_checker (
	input wire        clk_sys,
	input wire        reset_n,
	input wire        ex_valid,
	input wire [31:0] ex_pc,
	input wire [31:0] ex_link_addr,
	input wire        ex_is_branch,
	input wire        ex_delayed,
	input wire [2:0]  ex_kind,
	input wire [3:0]  ex_cond,
	input wire [31:0] ex_rel_target,
	input wire        ex_undefined,
	input wire        ex_soft_trap,
	input wire        ex_emulator_trap,
	input wire        ex_cop_absent,
	input wire        ex_cop_error,
	input wire        ex_return_from_event,
	input wire [31:0] general_register_operand,
	input wire [31:0] return_pointer,
	input wire        step_trace_en,
	input wire        nmi_req,
	input wire        irq_req,
	input wire        delayed_irq_req,
	input wire        redirect_valid_ff,
	input wire [31:0] redirect_pc_ff,
	input wire        flush_ff,
	input wire        slot_active_ff,
	input wire        slot_nop_ff,
	input wire [31:0] slot_rp_ff,
	input wire        rp_wr_en_ff,
	input wire        evt_enter_ff,
	input wire [7:0]  evt_vector_ff,
	input wire [31:0] evt_push_pc_ff,
	input wire        ps_restore_valid_ff,
	input wire [31:0] system_stack_pointer_ff
);
	// live retire, no fault cause, no pending request
	wire live  = ex_valid && !flush_ff;
	wire calm  = !(ex_undefined | ex_soft_trap | ex_emulator_trap | ex_cop_absent | ex_cop_error);
	wire quiet = calm && !(nmi_req | irq_req | delayed_irq_req | step_trace_en);
	wire brq   = live && quiet && ex_is_branch && !slot_active_ff && !ex_return_from_event;
	wire dly   = brq && ex_delayed;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_nd_taken;
		brq && !ex_delayed && ex_kind == `KIND_REL && ex_cond == `COND_ALWAYS
		|=> redirect_valid_ff && flush_ff && redirect_pc_ff == $past(ex_rel_target);
	endproperty
	property p_dl_never;
		dly && ex_kind == `KIND_REL && ex_cond == `COND_NEVER
		|=> slot_active_ff && !flush_ff && !redirect_valid_ff;
	endproperty
	property p_slot_end;
		slot_active_ff && ex_valid |=> !slot_active_ff;
	endproperty
	property p_ind;
		dly && (ex_kind == `KIND_JUMP_IND || ex_kind == `KIND_CALL_IND)
		|=> redirect_pc_ff == $past(general_register_operand);
	endproperty
	property p_ret;
		dly && ex_kind == `KIND_RETURN |=> redirect_valid_ff && redirect_pc_ff == $past(return_pointer);
	endproperty
	property p_call_rp;
		dly && (ex_kind == `KIND_CALL_REL || ex_kind == `KIND_CALL_IND)
		|=> rp_wr_en_ff && slot_rp_ff == $past(ex_link_addr);
	endproperty
	property p_slot_nop;
		live && slot_active_ff && ex_undefined
		&& !(ex_soft_trap | ex_emulator_trap | ex_cop_absent | ex_cop_error) |=> slot_nop_ff;
	endproperty
	property p_pair;
		live && ex_is_branch && ex_delayed && !slot_active_ff && calm |=> !evt_enter_ff;
	endproperty
	property p_undef;
		live && !slot_active_ff && ex_undefined |=> evt_enter_ff
		&& evt_vector_ff == `VEC_UNDEFINED && evt_push_pc_ff == $past(ex_pc);
	endproperty
	property p_ssp;
		evt_enter_ff && !ps_restore_valid_ff
		|-> system_stack_pointer_ff == $past(system_stack_pointer_ff) - `FRAME_BYTES;
	endproperty

	a_nd_taken: assert property (p_nd_taken)
		else $error("taken plain branch did not redirect and flush");
	a_dl_never: assert property (p_dl_never)
		else $error("untaken delayed branch lost its slot");
	a_slot_end: assert property (p_slot_end)
		else $error("slot flag outlived the slot");
	a_ind: assert property (p_ind)
		else $error("indirect target not the pre-slot operand");
	a_ret: assert property (p_ret)
		else $error("delayed return target wrong");
	a_call_rp: assert property (p_call_rp)
		else $error("slot return pointer not the call link");
	a_slot_nop: assert property (p_slot_nop)
		else $error("undefined slot not turned into nop");
	a_pair: assert property (p_pair)
		else $error("event taken between branch and slot");
	a_undef: assert property (p_undef)
		else $error("undefined opcode event wrong");
	a_ssp: assert property (p_ssp)
		else $error("stack pointer not lowered by frame");

	c_nd: cover property (flush_ff && redirect_valid_ff);
	c_call: cover property (slot_active_ff && rp_wr_en_ff);
	c_nop_evt: cover property (slot_nop_ff && evt_enter_ff);
endmodule

bind branch_sequencer seq_checker u_chk (.*);

// file: instr_stream.sv
// fetch side of the instruction stream: program counter of execute
// assumes redirect and event outputs are registered on clk_sys
`timescale 1ns/100ps
module instr_stream #(
	parameter [31:0] BOOT_PC    = 32'h0000_0100,
	parameter [31:0] HANDLER_PC = 32'h0000_0800
) (
	input  wire        clk_sys,
	input  wire        reset_n,
	input  wire        ex_valid,
	input  wire        redirect_valid_ff,
	input  wire [31:0] redirect_pc_ff,
	input  wire        evt_enter_ff,
	output reg  [31:0] ex_pc,
	output wire [31:0] ex_next_pc,
	output wire [31:0] ex_link_addr
);
	// halfword instructions; a call links past its slot
	assign ex_next_pc   = ex_pc + 32'h2;
	assign ex_link_addr = ex_pc + 32'h4;

	// slot fetched before target
	// event beats redirect; a redirect seen with the slot lands after it
	always @(posedge clk_sys) begin
		if (!reset_n)
			ex_pc <= BOOT_PC;
		else if (evt_enter_ff)
			ex_pc <= HANDLER_PC;
		else if (redirect_valid_ff)
			ex_pc <= redirect_pc_ff;
		else if (ex_valid)
			ex_pc <= ex_pc + 32'h2;
	end
endmodule

// file: tb_top.sv
// self-checking bench for the branch and event sequencer
// assumes instr_stream and seq_checker compiled alongside
`timescale 1ns/100ps
`include "branch_seq_defs.vh"
module tb_top;
	localparam [7:0] CA = 8'h0B;
	localparam [7:0] CE = 8'h0A;
	localparam [7:0] DI = 8'h3F;
	reg         clk_sys = 1'h0;
	reg         reset_n = 1'h0;
	reg         ex_valid, ex_is_branch, ex_delayed, ex_undefined, ex_soft_trap;
	reg         ex_emulator_trap, ex_cop_absent, ex_cop_error, ex_return_from_event;
	reg         step_trace_en, nmi_req, irq_req, delayed_irq_req;
	reg  [2:0]  ex_kind;
	reg  [3:0]  ex_cond, flags_nzvc, f;
	reg  [4:0]  irq_level, delayed_irq_level;
	reg  [7:0]  ex_soft_trap_vec, irq_vector;
	reg  [31:0] ex_rel_target, general_register_operand, return_pointer, program_status;
	reg  [31:0] restored_pc, restored_ps, exp_ssp, tgt, lnk;
	wire        redirect_valid_ff, flush_ff, slot_active_ff, slot_nop_ff, rp_wr_en_ff;
	wire        evt_enter_ff, ps_restore_valid_ff;
	wire [7:0]  evt_vector_ff;
	wire [31:0] redirect_pc_ff, slot_rp_ff, rp_wr_data_ff, evt_push_pc_ff, evt_push_ps_ff;
	wire [31:0] evt_push_addr_ff, ps_restore_ff, system_stack_pointer_ff;
	wire [31:0] ex_pc, ex_next_pc, ex_link_addr;
	int         n_errors = 0;
	int         total_checks = 0;
	int         i;
	logic [39:0] q[$];
	logic [7:0]  vecs [0:8] = '{`VEC_UNDEFINED, CA, CE, 8'h40, `VEC_EMULATOR, `VEC_NMI, DI,
		8'h20, `VEC_STEP_TRACE};

	branch_sequencer #(.COP_ABSENT_VEC(CA), .COP_ERROR_VEC(CE), .DELAYED_IRQ_VEC(DI)) DUT (.*);
	instr_stream u_fetch (.*);

	always #50 clk_sys = ~clk_sys;

	// ----------------------------------------------------------------
	// compare, report, expectation queue
	// ----------------------------------------------------------------
	task chk(input [39:0] seen, input [39:0] exp, input string nm);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task ex(input [7:0] c, input [31:0] d);
		q.push_back({c, d});
	endtask
	task see(input [7:0] c, input [31:0] d);
		if (q.size() == 0)
			chk({c, d}, 40'h0, "unexpected result");
		else
			chk({c, d}, q.pop_front(), "result");
	endtask

	// monitor: settled outputs, fixed order within a cycle
	always @(posedge clk_sys) begin
		#5;
		if (reset_n) begin
			if (redirect_valid_ff && !evt_enter_ff) see(flush_ff ? 8'h01 : 8'h07, redirect_pc_ff);
			if (evt_enter_ff) see(8'h02, evt_push_pc_ff);
			if (evt_enter_ff) see(8'h03, {24'h0, evt_vector_ff});
			if (rp_wr_en_ff && !evt_enter_ff) see(8'h04, rp_wr_data_ff);
			if (slot_nop_ff) see(8'h05, 32'h0);
			if (ps_restore_valid_ff) see(8'h06, ps_restore_ff);
			if (evt_enter_ff) see(8'h08, evt_push_addr_ff);
			if (evt_enter_ff) chk(evt_push_ps_ff, 32'h001F_0010, "push_ps");
		end
	end

	// ----------------------------------------------------------------
	// driver helpers
	// ----------------------------------------------------------------
	function automatic logic take(input [3:0] c, input [3:0] fl);
		logic r;
		case (c[3:1])
		3'h0: r = 1'h1;
		3'h1: r = fl[2];
		3'h2: r = fl[0];
		3'h3: r = fl[3];
		3'h4: r = fl[1];
		3'h5: r = fl[3] ^ fl[1];
		3'h6: r = (fl[3] ^ fl[1]) | fl[2];
		default: r = fl[0] | fl[2];
		endcase
		return r ^ c[0];
	endfunction
	task tick;
		@(posedge clk_sys);
		#1;
	endtask
	// plain one-cycle instruction with fresh operands
	task idle;
		ex_valid = 1'h1;
		{ex_is_branch, ex_delayed, ex_undefined, ex_soft_trap, ex_emulator_trap} = 5'h00;
		{ex_cop_absent, ex_cop_error, ex_return_from_event, ex_kind, ex_cond} = 10'h000;
		{step_trace_en, nmi_req, irq_req, delayed_irq_req} = 4'h0;
		ex_rel_target = $urandom & 32'hFFFF_FFFE;
		general_register_operand = $urandom;
		return_pointer = $urandom;
		flags_nzvc = 4'($urandom);
		restored_pc = $urandom & 32'hFFFF_FFFE;
		restored_ps = $urandom;
	endtask
	// wrong-path instruction: a fault here shows if it is not killed
	task dead;
		idle;
		ex_undefined = 1'h1;
		tick;
	endtask
	task brn(input [2:0] k, input [3:0] c, input d);
		idle;
		{ex_is_branch, ex_delayed, ex_kind, ex_cond} = {1'h1, d, k, c};
	endtask

	initial begin
		repeat (3000) @(posedge clk_sys);
		n_errors++;
		wrap_up;
	end

	initial begin
		void'($urandom(47));
		idle;
		ex_valid = 1'h0;
		{ex_soft_trap_vec, irq_vector, irq_level, delayed_irq_level} = {8'h40, 8'h20, 5'h12, 5'h10};
		program_status = 32'h001F_0010;
		exp_ssp = `SSP_RESET;
		repeat (8) @(posedge clk_sys);
		#1 reset_n = 1'h1;
		brn(`KIND_REL, `COND_ALWAYS, 1'h0);
		ex(8'h01, ex_rel_target);
		tick;
		dead;
		brn(`KIND_REL, `COND_NEVER, 1'h0);
		tick;
		idle;
		ex_emulator_trap = 1'h1;
		ex(8'h02, ex_next_pc);
		ex(8'h03, {24'h0, `VEC_EMULATOR});
		exp_ssp = exp_ssp - `FRAME_BYTES;
		ex(8'h08, exp_ssp);
		tick;
		dead;
		for (i = 0; i < 16; i++) begin
			brn(`KIND_REL, 4'(i), 1'h1);
			if (take(ex_cond, flags_nzvc)) ex(8'h07, ex_rel_target);
			f = flags_nzvc;
			tick;
			idle;
			flags_nzvc = ~f;
			chk(slot_active_ff, 1'h1, "slot_active");
			tick;
		end
		for (i = 1; i < 5; i++) begin
			brn(3'(i), `COND_ALWAYS, 1'h1);
			ex(8'h07, i == 2 ? ex_rel_target : i == 4 ? return_pointer : general_register_operand);
			if (i == 2 || i == 3) ex(8'h04, ex_link_addr);
			lnk = ex_link_addr;
			tick;
			idle;
			if (i == 2 || i == 3) chk(slot_rp_ff, lnk, "slot_rp");
			tick;
		end
		brn(`KIND_REL, `COND_ALWAYS, 1'h1);
		{nmi_req, step_trace_en} = 2'h3;
		ex(8'h07, ex_rel_target);
		tgt = ex_rel_target;
		tick;
		idle;
		{nmi_req, ex_undefined} = 2'h3;
		ex(8'h02, tgt);
		ex(8'h03, {24'h0, `VEC_NMI});
		ex(8'h05, 32'h0);
		exp_ssp = exp_ssp - `FRAME_BYTES;
		ex(8'h08, exp_ssp);
		tick;
		dead;
		// each cause once, back to back
		for (i = 0; i < 9; i++) begin
			idle;
			{ex_undefined, ex_cop_absent, ex_cop_error, ex_soft_trap, ex_emulator_trap, nmi_req,
				delayed_irq_req, irq_req, step_trace_en} = 9'h100 >> i;
			ex(8'h02, i == 0 ? ex_pc : ex_next_pc);
			ex(8'h03, {24'h0, vecs[i]});
			exp_ssp = exp_ssp - `FRAME_BYTES;
			ex(8'h08, exp_ssp);
			tick;
			dead;
		end
		// level equal to mask is refused
		idle;
		irq_req = 1'h1;
		program_status[20:16] = irq_level;
		tick;
		program_status = 32'h001F_0010;
		idle;
		tick;
		chk(system_stack_pointer_ff, exp_ssp, "ssp_after_events");
		repeat (2) begin
			idle;
			ex_return_from_event = 1'h1;
			ex(8'h01, restored_pc);
			ex(8'h06, restored_ps);
			exp_ssp = exp_ssp + `FRAME_BYTES;
			tick;
			dead;
			ex_valid = 1'h0;
			repeat ($urandom % 3) tick;
		end
		chk(system_stack_pointer_ff, exp_ssp, "ssp_after_return");
		ex_valid = 1'h0;
		for (i = 0; i < 10 && q.size() != 0; i++) tick;
		chk(q.size(), 40'h0, "missing results");
		wrap_up;
	end
endmodule
